//--- design/asc_chopper_ctrl.sv
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`include "asc_cfg.svh"
module asc_chopper_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        slow_sample_clock,
  input  wire logic        system_supply_sense,
  input  wire logic        interval_last_next,
  input  wire logic        conv_done,
  input  wire logic [23:0] conv_result,
  output logic             conv_start,
  output logic [3:0]       conv_sel,
  output logic [9:0]       fir_cycles,
  output logic [4:0]       fir_resolution,
  output logic             chopper_polarity,
  output logic             chopper_clock_out,
  output logic             frame_sync_pulse,
  output logic             monitor_readout_start,
  output logic             cell_load_switch,
  output logic             alt_frame_active
);
  asc_pkg::asc_word_t ctrl_r, sel0_r, sel1_r, alt0_r, alt1_r;
  asc_pkg::asc_word_t ram_r [0:`ASC_RAM_WORDS-1];
  asc_pkg::asc_seq_t  state_r;
  logic       ck_s, ck_prev_r, supply_s;
  logic [3:0] slot_r;
  logic [1:0] cyc_r;
  logic       alt_prev_r, alt_pend_r, par_r, cur_last_r;
  logic       start_req_r, wr_ok_r;
  logic [3:0] wr_word_r;

  // the sample clock is a foreign pin; it is only ever seen as a tick
  asc_sync2 u_ck_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (slow_sample_clock),
    .q       (ck_s)
  );
  asc_sync2 u_sup_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (system_supply_sense),
    .q       (supply_s)
  );

  wire       ck_tick   = ck_s & ~ck_prev_r;
  wire [1:0] mode_w    = {ctrl_r[`ASC_F_MHI], ctrl_r[`ASC_F_MLO]};
  wire       wide_w    = (mode_w == `ASC_MODE_WIDE);
  wire [1:0] len_w     = ctrl_r[`ASC_F_LEN];
  wire [1:0] chop_w    = ctrl_r[`ASC_F_CHOP];
  wire [3:0] div_raw   = ctrl_r[`ASC_F_DIV];
  wire       bme_eff_w = ctrl_r[`ASC_F_BME] & supply_s;

  // resolution table; length code 3 behaves as code 2
  wire [9:0] cyc_n_w = (len_w == 2'h0) ? `ASC_CYC_N0 : (len_w == 2'h1) ? `ASC_CYC_N1 : `ASC_CYC_N2;
  wire [9:0] cyc_w_w = (len_w == 2'h0) ? `ASC_CYC_W0 : (len_w == 2'h1) ? `ASC_CYC_W1 : `ASC_CYC_W2;
  wire [4:0] res_n_w = (len_w == 2'h0) ? `ASC_RES_N0 : (len_w == 2'h1) ? `ASC_RES_N1 : `ASC_RES_N2;
  wire [4:0] res_w_w = (len_w == 2'h0) ? `ASC_RES_W0 : (len_w == 2'h1) ? `ASC_RES_W1 : `ASC_RES_W2;
  wire [9:0] cyc_sel = wide_w ? cyc_w_w : cyc_n_w;
  wire [4:0] res_sel = wide_w ? res_w_w : res_n_w;

  // conversion spans 1, 2 or 3 sample-clock cycles
  wire [1:0] conv_len_w = (len_w == 2'h3) ? 2'h3 : len_w + 2'h1;
  // zero and values above ten are clamped so a frame always runs
  wire [3:0] ndiv_w = (div_raw == 4'h0) ? 4'h1 : (div_raw > `ASC_DIV_MAX) ? `ASC_DIV_MAX : div_raw;

  wire [79:0] nsel_w  = {sel1_r[15:0], sel0_r};
  wire [79:0] asel_w  = {alt1_r[15:0], alt0_r};
  wire [6:0]  sel_lsb = {1'b0, slot_r, 2'b00};
  wire [3:0]  cur_sel = alt_frame_active ? asel_w[sel_lsb +: 4] : nsel_w[sel_lsb +: 4];

  // these signal numbers own a data word in every frame; the battery word is gated below
  wire sig_plain = (cur_sel <= `ASC_SIG_LASTD) || (cur_sel == `ASC_SIG_TEMP);
  // battery only in alternate frames and only while enabled
  wire sig_bat   = (cur_sel == `ASC_SIG_BAT) && alt_frame_active && bme_eff_w;
  wire sig_ok    = sig_plain | sig_bat;

  wire slot_end  = (cyc_r == conv_len_w - 2'h1);
  // a smaller slot count written mid-frame ends the frame at the end of the current slot instead of wrapping
  wire frame_end = slot_end && (slot_r >= ndiv_w - 4'h1);
  wire run_tick  = ck_tick && (state_r == asc_pkg::SEQ_RUN);
  wire set_tick  = ck_tick && (state_r == asc_pkg::SEQ_SETTLE);
  wire go_settle = run_tick && frame_end;
  wire next_slot = run_tick && slot_end && !frame_end;

  // the next frame may close the interval only if that makes it even
  wire last_ok_w = interval_last_next && !cur_last_r && par_r;
  wire force_alt = (chop_w == `ASC_CHOP_TOGA) && last_ok_w;
  wire alt_rise  = ctrl_r[`ASC_F_ALT] & ~alt_prev_r;

  wire pol_nxt = (chop_w == `ASC_CHOP_POS) ? 1'b0 :
                 (chop_w == `ASC_CHOP_REV) ? 1'b1 :
                 (force_alt ? chopper_polarity : ~chopper_polarity);

  // mask to the active resolution, then move up eight bits
  wire [31:0] res_mask = 32'hFFFF_FFFF >> (6'h20 - {1'b0, fir_resolution});
  wire [31:0] wdata_w  = ({8'h00, conv_result} & res_mask) << `ASC_SHIFT;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_prev_r <= 1'b0;
    end else begin
      ck_prev_r <= ck_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r               <= asc_pkg::SEQ_SETTLE;
      slot_r                <= 4'h0;
      cyc_r                 <= 2'h0;
      frame_sync_pulse      <= 1'b0;
      monitor_readout_start <= 1'b0;
      chopper_polarity      <= 1'b0;
      alt_frame_active      <= 1'b0;
      par_r                 <= 1'b0;
      cur_last_r            <= 1'b0;
      start_req_r           <= 1'b0;
    end else begin
      monitor_readout_start <= go_settle;
      start_req_r           <= set_tick | next_slot;
      unique case (state_r)
        asc_pkg::SEQ_SETTLE: begin
          if (ck_tick) begin
            state_r          <= asc_pkg::SEQ_RUN;
            slot_r           <= 4'h0;
            cyc_r            <= 2'h0;
            frame_sync_pulse <= 1'b0;
          end
        end
        asc_pkg::SEQ_RUN: begin
          if (go_settle) begin
            state_r          <= asc_pkg::SEQ_SETTLE;
            frame_sync_pulse <= 1'b1;
            chopper_polarity <= pol_nxt;
            alt_frame_active <= alt_pend_r | force_alt;
            cur_last_r       <= last_ok_w;
            par_r            <= cur_last_r ? 1'b1 : ~par_r;
          end else if (next_slot) begin
            slot_r <= slot_r + 4'h1;
            cyc_r  <= 2'h0;
          end else if (run_tick) begin
            cyc_r <= cyc_r + 2'h1;
          end
        end
      endcase
    end
  end

  // a rise arriving as the pending request is taken is kept for the next frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_prev_r <= 1'b0;
      alt_pend_r <= 1'b0;
    end else begin
      alt_prev_r <= ctrl_r[`ASC_F_ALT];
      alt_pend_r <= alt_rise | (alt_pend_r & ~go_settle);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_start        <= 1'b0;
      conv_sel          <= 4'h0;
      wr_ok_r           <= 1'b0;
      wr_word_r         <= 4'h0;
      fir_cycles        <= `ASC_CYC_N0;
      fir_resolution    <= `ASC_RES_N0;
      cell_load_switch  <= 1'b0;
      chopper_clock_out <= 1'b0;
    end else begin
      conv_start        <= start_req_r & sig_ok;
      fir_cycles        <= cyc_sel;
      fir_resolution    <= res_sel;
      cell_load_switch  <= bme_eff_w;
      chopper_clock_out <= chopper_polarity;
      if (start_req_r) begin
        conv_sel  <= cur_sel;
        wr_ok_r   <= sig_ok;
        wr_word_r <= cur_sel;
      end
    end
  end

  // data words carry no reset; software must not trust them before a frame
  always_ff @(posedge pclk) begin
    if (conv_done && wr_ok_r && wr_word_r <= `ASC_RAM_TOP) begin
      ram_r[wr_word_r] <= wdata_w;
    end
  end

  // apb slave: one wait state, pready and prdata from flops
  wire        acc_w    = psel & penable;
  wire        done_w   = acc_w & pready;
  wire        hit_ctrl = (paddr == `ASC_A_CTRL);
  wire        hit_sel0 = (paddr == `ASC_A_SEL0);
  wire        hit_sel1 = (paddr == `ASC_A_SEL1);
  wire        hit_alt0 = (paddr == `ASC_A_ALT0);
  wire        hit_alt1 = (paddr == `ASC_A_ALT1);
  wire        hit_stat = (paddr == `ASC_A_STAT);
  wire        hit_ram  = (paddr[7:6] == `ASC_A_RAM) && (paddr[1:0] == 2'h0);
  wire [3:0]  ram_idx  = paddr[5:2];
  wire        mapped   = hit_ctrl | hit_sel0 | hit_sel1 | hit_alt0 | hit_alt1 | hit_stat | hit_ram;
  wire [31:0] stat_w   = {20'h0, slot_r, alt_pend_r, alt_frame_active, par_r, cur_last_r,
                          (state_r == asc_pkg::SEQ_SETTLE), chopper_polarity, bme_eff_w, supply_s};
  wire [31:0] ram_rd   = (ram_idx <= `ASC_RAM_TOP) ? ram_r[ram_idx] : 32'h0000_0000;
  wire [31:0] rd_w     = hit_ctrl ? ctrl_r : hit_sel0 ? sel0_r : hit_sel1 ? sel1_r :
                         hit_alt0 ? alt0_r : hit_alt1 ? alt1_r : hit_stat ? stat_w :
                         hit_ram ? ram_rd : 32'h0000_0000;
  wire        wr_en    = done_w & pwrite & mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= acc_w & ~pready;
      pslverr <= acc_w & ~pready & ~mapped;
      prdata  <= (acc_w & ~pready & ~pwrite) ? rd_w : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `ASC_RST_CTRL;
      sel0_r <= `ASC_RST_SEL0;
      sel1_r <= `ASC_RST_SEL1;
      alt0_r <= `ASC_RST_ALT0;
      alt1_r <= `ASC_RST_ALT1;
    end else if (wr_en) begin
      if (hit_ctrl) ctrl_r <= pwdata & `ASC_CTRL_MASK;
      if (hit_sel0) sel0_r <= pwdata;
      if (hit_sel1) sel1_r <= {16'h0, pwdata[15:0]};
      if (hit_alt0) alt0_r <= pwdata;
      if (hit_alt1) alt1_r <= {16'h0, pwdata[15:0]};
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_fixed_low: assert property (
    $rose(frame_sync_pulse) && $past(chop_w) == `ASC_CHOP_POS |-> !chopper_polarity ##1 !chopper_clock_out)
    else $error("polarity not held low in setting 01");
  a_fixed_high: assert property (
    $rose(frame_sync_pulse) && $past(chop_w) == `ASC_CHOP_REV |-> chopper_polarity ##1 chopper_clock_out)
    else $error("polarity not held high in setting 10");
  a_toggle_all: assert property (
    $rose(frame_sync_pulse) && $past(chop_w) == `ASC_CHOP_TOG
      |-> chopper_polarity != $past(chopper_polarity) && (!alt_frame_active || $past(alt_pend_r)))
    else $error("setting 11 missed a toggle or forced a frame");
  a_skip_toggle: assert property (
    $rose(frame_sync_pulse) && $past(force_alt) |-> chopper_polarity == $past(chopper_polarity))
    else $error("toggle not skipped before forced frame");
  a_force_alt: assert property (
    $rose(frame_sync_pulse) && $past(force_alt) |-> alt_frame_active)
    else $error("alternate frame not forced");
  a_settle_len: assert property (
    $fell(frame_sync_pulse) |-> $past(ck_tick) && state_r == asc_pkg::SEQ_RUN && slot_r == 4'h0)
    else $error("settling cycle not ended by a sample tick");
  a_pass_start: assert property (
    $rose(frame_sync_pulse) |-> monitor_readout_start ##1 !monitor_readout_start)
    else $error("monitor readout not started with the pass");
  a_bat_gate: assert property (
    conv_start && conv_sel == `ASC_SIG_BAT |-> alt_frame_active && $past(bme_eff_w))
    else $error("battery converted outside an enabled alternate frame");
  a_load_supply: assert property (
    cell_load_switch |-> $past(supply_s))
    else $error("battery load applied without main supply");
  a_data_shift: assert property (
    conv_done && wr_ok_r |-> wdata_w[7:0] == 8'h00 && (wdata_w >> ({1'b0, fir_resolution} + 6'h08)) == 32'h0)
    else $error("stored word not shifted or masked");
  a_start_tick: assert property (
    conv_start |-> $past(ck_tick, 2))
    else $error("conversion not started on a sample-clock rise");

  // the frame boundary is the only place where polarity and frame type may move
  a_sync_hold: assert property (
    frame_sync_pulse && !ck_tick |=> frame_sync_pulse)
    else $error("frame sync dropped inside the settling cycle");
  a_pol_steady: assert property (
    $changed(chopper_polarity) |-> $rose(frame_sync_pulse))
    else $error("polarity moved outside the start of settling");
  a_alt_steady: assert property (
    $changed(alt_frame_active) |-> $rose(frame_sync_pulse))
    else $error("alternate frame state moved off a frame boundary");
  a_ram_word: assert property (
    conv_start |-> conv_sel <= `ASC_SIG_LASTD || conv_sel == `ASC_SIG_TEMP || conv_sel == `ASC_SIG_BAT)
    else $error("conversion started for a signal with no data word");
  a_load_follow: assert property (
    $past(ctrl_r[`ASC_F_BME]) && $past(supply_s) |-> cell_load_switch)
    else $error("battery load not applied while enabled");
  a_slot_limit: assert property (
    slot_r < `ASC_DIV_MAX)
    else $error("slot counter beyond ten states");
  a_fir_table: assert property (
    $past(len_w) == 2'h0 |-> fir_cycles == ($past(wide_w) ? `ASC_CYC_W0 : `ASC_CYC_N0))
    else $error("filter cycle count does not follow the mode bits");
  a_bat_word: assert property (
    conv_done && wr_ok_r && wr_word_r == `ASC_SIG_BAT |=> ram_r[`ASC_SIG_BAT] == $past(wdata_w))
    else $error("battery result not stored in its data word");

  c_alt_frame: cover property ($rose(alt_frame_active));
  c_forced:    cover property ($rose(frame_sync_pulse) && $past(force_alt));
  c_battery:   cover property (conv_start && conv_sel == `ASC_SIG_BAT);
  c_fixed_rev: cover property ($rose(frame_sync_pulse) && chop_w == `ASC_CHOP_REV);
  c_settle:    cover property ($fell(frame_sync_pulse));
endmodule // asc_chopper_ctrl

//--- common/asc_cfg.svh
`ifndef ASC_CFG_SVH
`define ASC_CFG_SVH
// register byte offsets
`define ASC_A_CTRL    8'h00
`define ASC_A_SEL0    8'h04
`define ASC_A_SEL1    8'h08
`define ASC_A_ALT0    8'h0C
`define ASC_A_ALT1    8'h10
`define ASC_A_STAT    8'h14
`define ASC_A_RAM     2'h1
// control fields
`define ASC_F_MLO     0
`define ASC_F_MHI     1
`define ASC_F_LEN     3:2
`define ASC_F_CHOP    5:4
`define ASC_F_BME     6
`define ASC_F_ALT     7
`define ASC_F_DIV     11:8
`define ASC_CTRL_MASK 32'h0000_0FFF
// reset values
`define ASC_RST_CTRL  32'h0000_0700
`define ASC_RST_SEL0  32'h0654_3210
`define ASC_RST_SEL1  32'h0000_0000
`define ASC_RST_ALT0  32'h0654_3B1A
`define ASC_RST_ALT1  32'h0000_0000
// chopper settings and wide mode code
`define ASC_CHOP_TOGA 2'h0
`define ASC_CHOP_POS  2'h1
`define ASC_CHOP_REV  2'h2
`define ASC_CHOP_TOG  2'h3
`define ASC_MODE_WIDE 2'h1
// filter cycles and resolution
`define ASC_CYC_N0    10'h08A
`define ASC_CYC_N1    10'h120
`define ASC_CYC_N2    10'h180
`define ASC_CYC_W0    10'h0BA
`define ASC_CYC_W1    10'h180
`define ASC_CYC_W2    10'h24C
`define ASC_RES_N0    5'h12
`define ASC_RES_N1    5'h15
`define ASC_RES_N2    5'h16
`define ASC_RES_W0    5'h13
`define ASC_RES_W1    5'h16
`define ASC_RES_W2    5'h18
// signals and data ram
`define ASC_SIG_LASTD 4'h6
`define ASC_SIG_TEMP  4'hA
`define ASC_SIG_BAT   4'hB
`define ASC_RAM_WORDS 12
`define ASC_RAM_TOP   4'hB
`define ASC_SHIFT     8
`define ASC_DIV_MAX   4'hA
`endif

//--- common/asc_pkg.sv
package asc_pkg;
  typedef enum logic [0:0] {
    SEQ_SETTLE,
    SEQ_RUN
  } asc_seq_t;
  typedef logic [31:0] asc_word_t;
endpackage

//--- design/asc_sync2.sv
`timescale 1ns/10ps
module asc_sync2 (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic d,
  output logic      q
);
  logic meta_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // asc_sync2

//--- testbench/asc_conv_model.sv
`timescale 1ns/10ps
module asc_conv_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        conv_start,
  input  wire logic [3:0]  conv_sel,
  output logic             conv_done,
  output logic [23:0]      conv_result
);
  logic [3:0] sel_r;
  logic [4:0] cnt_r;
  logic       busy_r;
  // latency grows with the signal number so slow and quick answers both occur
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_r       <= 4'h0;
      cnt_r       <= 5'h00;
      busy_r      <= 1'b0;
      conv_done   <= 1'b0;
      conv_result <= 24'h000000;
    end else if (conv_start) begin
      sel_r     <= conv_sel;
      cnt_r     <= 5'h03 + {1'b0, conv_sel};
      busy_r    <= 1'b1;
      conv_done <= 1'b0;
    end else if (busy_r && cnt_r == 5'h00) begin
      // upper bits beyond the resolution are junk the block must drop
      conv_result <= 24'hF12300 | {20'h00000, sel_r};
      conv_done   <= 1'b1;
      busy_r      <= 1'b0;
    end else begin
      cnt_r     <= cnt_r - 5'h01;
      conv_done <= 1'b0;
      // result is not held once the strobe is gone
      if (conv_done) conv_result <= ~conv_result;
    end
  end
endmodule // asc_conv_model

//--- testbench/tb_top.sv
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
  $display("Error %0t: got %h want %h", $time, (a), (b)); end end
module tb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        slow_sample_clock = 1'b0;
  logic        system_supply_sense = 1'b1;
  logic        interval_last_next = 1'b0;
  logic        conv_done;
  logic [23:0] conv_result;
  logic        conv_start;
  logic [3:0]  conv_sel;
  logic [9:0]  fir_cycles;
  logic [4:0]  fir_resolution;
  logic        chopper_polarity;
  logic        chopper_clock_out;
  logic        frame_sync_pulse;
  logic        monitor_readout_start;
  logic        cell_load_switch;
  logic        alt_frame_active;
  logic [4:0]  sdiv = 5'h00;
  int          fail_count = 0;
  int          comparisons = 0;

  always #25 pclk = ~pclk;
  // sample clock far faster than 32768 Hz to keep the run short
  always @(posedge pclk) begin
    if (sdiv == 5'h13) begin
      sdiv <= 5'h00;
      slow_sample_clock <= ~slow_sample_clock;
    end else sdiv <= sdiv + 5'h01;
  end

  asc_chopper_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slow_sample_clock(slow_sample_clock), .system_supply_sense(system_supply_sense),
    .interval_last_next(interval_last_next), .conv_done(conv_done), .conv_result(conv_result),
    .conv_start(conv_start), .conv_sel(conv_sel), .fir_cycles(fir_cycles), .fir_resolution(fir_resolution),
    .chopper_polarity(chopper_polarity), .chopper_clock_out(chopper_clock_out),
    .frame_sync_pulse(frame_sync_pulse), .monitor_readout_start(monitor_readout_start),
    .cell_load_switch(cell_load_switch), .alt_frame_active(alt_frame_active));
  asc_conv_model conv (.pclk(pclk), .presetn(presetn), .conv_start(conv_start), .conv_sel(conv_sel),
    .conv_done(conv_done), .conv_result(conv_result));

  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic timeout();
    fail_count++;
    $display("Error %0t: wait ran out", $time);
    give_verdict();
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // read right after the edge: these are the values the slave held into it
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 50) timeout();
    q = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h00000000, q, e);
    `CHK(q, x)
    `CHK(e, xe)
  endtask

  // returns on the first low edge that sees a fresh frame sync
  task automatic wait_sync();
    int n;
    logic prev;
    prev = frame_sync_pulse;
    for (n = 0; n < 3000; n++) begin
      @(negedge pclk);
      if (frame_sync_pulse === 1'b1 && prev === 1'b0) break;
      prev = frame_sync_pulse;
    end
    if (n == 3000) timeout();
    `CHK(monitor_readout_start, 1'b1)
  endtask

  task automatic t_reset();
    `CHK(fir_cycles, 10'h08A)
    `CHK(fir_resolution, 5'h12)
    rd_chk(8'h00, 32'h00000700, 1'b0);
    rd_chk(8'h04, 32'h06543210, 1'b0);
    rd_chk(8'h0C, 32'h06543B1A, 1'b0);
    rd_chk(8'h30, 32'h00000000, 1'b1);
  endtask

  task automatic t_fir();
    logic [9:0] cyc [6] = '{10'h08A, 10'h120, 10'h180, 10'h0BA, 10'h180, 10'h24C};
    logic [4:0] res [6] = '{5'h12, 5'h15, 5'h16, 5'h13, 5'h16, 5'h18};
    int m, l, k;
    for (m = 0; m < 4; m++) begin
      for (l = 0; l < 3; l++) begin
        wr(8'h00, 32'h00000300 | m | (l << 2));
        repeat (3) @(negedge pclk);
        k = (m == 1) ? 3 + l : l;
        `CHK(fir_cycles, cyc[k])
        `CHK(fir_resolution, res[k])
      end
    end
  endtask

  task automatic t_fixed(input logic [1:0] c, input logic lvl);
    wr(8'h00, 32'h00000200 | (c << 4));
    wait_sync();
    wait_sync();
    repeat (2) @(negedge pclk);
    `CHK(chopper_polarity, lvl)
    `CHK(chopper_clock_out, lvl)
  endtask

  task automatic t_toggle();
    logic p;
    int i;
    wr(8'h00, 32'h00000230);
    wait_sync();
    p = chopper_polarity;
    for (i = 0; i < 4; i++) begin
      wait_sync();
      `CHK(chopper_polarity, ~p)
      p = chopper_polarity;
      @(negedge pclk);
      `CHK(chopper_clock_out, p)
    end
  endtask

  task automatic t_data();
    wait_sync();
    wait_sync();
    rd_chk(8'h40, ((32'h00F12300 | 32'h0) & 32'h3FFFF) << 8, 1'b0);
    rd_chk(8'h44, ((32'h00F12300 | 32'h1) & 32'h3FFFF) << 8, 1'b0);
  endtask

  task automatic t_alt();
    int n, seen;
    logic [31:0] q;
    logic        e;
    wr(8'h00, 32'h00000370);
    repeat (3) @(negedge pclk);
    `CHK(cell_load_switch, 1'b1)
    wr(8'h00, 32'h000003F0);
    for (n = 0; n < 3000 && alt_frame_active !== 1'b1; n++) @(negedge pclk);
    if (n == 3000) timeout();
    for (n = 0; n < 3000 && alt_frame_active !== 1'b0; n++) @(negedge pclk);
    if (n == 3000) timeout();
    rd_chk(8'h68, ((32'h00F12300 | 32'hA) & 32'h3FFFF) << 8, 1'b0);
    rd_chk(8'h6C, ((32'h00F12300 | 32'hB) & 32'h3FFFF) << 8, 1'b0);
    seen = 0;
    for (n = 0; n < 400; n++) begin
      @(negedge pclk);
      if (alt_frame_active === 1'b1) seen++;
    end
    `CHK(seen, 0)
    @(posedge pclk);
    system_supply_sense <= 1'b0;
    repeat (5) @(negedge pclk);
    `CHK(cell_load_switch, 1'b0)
    apb(1'b0, 8'h14, 32'h00000000, q, e);
    `CHK(q[1:0], 2'b00)
    `CHK(e, 1'b0)
  endtask

  // interval end held high: every second frame closes an interval and is forced alternate
  task automatic t_forced();
    logic p;
    int i, last, forced;
    wr(8'h00, 32'h00000300);
    @(posedge pclk);
    interval_last_next <= 1'b1;
    wait_sync();
    p = chopper_polarity;
    last = 0;
    forced = 0;
    for (i = 1; i <= 8; i++) begin
      wait_sync();
      `CHK(chopper_polarity, alt_frame_active ? p : ~p)
      if (alt_frame_active === 1'b1) begin
        if (forced > 0) `CHK((i - last) % 2, 0)
        forced++;
        last = i;
      end
      p = chopper_polarity;
    end
    `CHK(forced > 1, 1'b1)
    @(posedge pclk);
    interval_last_next <= 1'b0;
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    t_reset();
    t_fir();
    t_fixed(2'h1, 1'b0);
    t_fixed(2'h2, 1'b1);
    t_toggle();
    t_data();
    t_alt();
    t_forced();
    give_verdict();
  end
endmodule // tb_top
